// file: bench/hif_core_tb.sv
// Self-checking bench for hif_core: reset load, filters, idle timing, memory reads, sleep.
// Assumes hif_host drives the register port; the bench drives the front-end sample.
`timescale 1ns/1ps
`default_nettype none
module hif_core_tb;
  import hif_pkg::*;

  function automatic logic [7:0] nvm_byte(input int a);
    case (a)
      6: return 8'h01;
      8: return 8'h03;
      12: return 8'h25;
      default: return 8'(a * 29) ^ 8'h5a;
    endcase
  endfunction

  function automatic logic [NVM_DEPTH*8-1:0] mk_img();
    logic [NVM_DEPTH*8-1:0] img;
    for (int a = 0; a < NVM_DEPTH; a++) img[a*8+:8] = nvm_byte(a);
    return img;
  endfunction

  localparam logic [NVM_DEPTH*8-1:0] IMG = mk_img();
  logic ref_clk;
  logic reset_n;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  logic [7:0] st;
  logic [6:0] a;
  logic [SAMPLE_W-1:0] afe_sample;
  logic [SAMPLE_W-1:0] va;
  logic [SAMPLE_W-1:0] vb;
  logic meas_active;
  logic afe_power;
  logic [15:0] lfsr;
  logic [7:0] ivs [3] = '{8'h01, 8'h02, 8'h21};
  logic [6:0] nv_tbl [5] = '{7'h14, 7'h15, 7'h1d, 7'h1e, 7'h7f};
  int num_errors;
  int checks;
  int gap;
  int len;
  int l0;
  int n;
  int s;
  int g [3];

  hif_core #(.WAKE_CYC(200), .NVM_IMAGE(IMG)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .afe_sample(afe_sample), .meas_active(meas_active), .afe_power(afe_power)
  );

  hif_host host_u (
    .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [14:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[14:0];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_sig(input bit pwr, input logic lvl, output int cnt);
    cnt = 0;
    while (((pwr ? afe_power : meas_active) !== lvl) && cnt < 9000) begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt >= 9000) chk(16'h1, 16'h0);
  endtask

  // The sample only changes while meas_active is low, so every burst sees one constant value.
  task automatic burst(input logic [14:0] smp, output int gp, output int ln);
    wait_sig(1'b0, 1'b0, gp);
    afe_sample = smp;
    wait_sig(1'b0, 1'b1, gp);
    wait_sig(1'b0, 1'b0, ln);
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic rd_res(input logic [14:0] v);
    host_u.rd(REG_RES_HI, d);
    chk(16'(d), {8'h0, 1'b1, v[14:8]});
    host_u.rd(REG_RES_LO, d);
    chk(16'(d), {8'h0, v[7:0]});
  endtask

  initial begin
    #950000;
    num_errors++;
    stop_test();
  end

  initial begin
    num_errors = 0;
    checks = 0;
    lfsr = 16'd66;
    reset_n = 1'b0;
    afe_sample = 15'h7fff;
    repeat (2) @(negedge ref_clk);
    chk(16'(meas_active), 16'h0);
    chk(16'(afe_power), 16'h0);
    chk(16'(reg_rdata), 16'h0);
    reset_n = 1'b1;
    repeat (14) @(negedge ref_clk);
    for (int i = 4; i < 16; i++) begin
      host_u.rd(8'(i), d);
      chk(16'(d), 16'(nvm_byte(i)));
    end
    wait_sig(1'b0, 1'b1, n);
    wait_sig(1'b0, 1'b0, n);
    repeat (4) @(negedge ref_clk);
    rd_res(15'h7fff);
    host_u.rd(REG_RES_HI, d);
    chk(16'(d[7]), 16'h0);
    vb = rnd();
    burst(vb, gap, len);
    s = 4 * 32767;
    s = s - (s >> 2) + int'(vb);
    rd_res(15'(s >> 2));
    host_u.wr(NVM_FILTER_CONFIG, 8'h00);
    va = rnd();
    burst(va, gap, l0);
    burst(va, gap, l0);
    rd_res(va);
    host_u.wr(NVM_FILTER_CONFIG, 8'h04);
    burst(va, gap, len);
    vb = rnd();
    burst(vb, gap, len);
    rd_res(vb);
    chk(16'(len - l0), 16'd2640);
    host_u.wr(NVM_FILTER_CONFIG, 8'h00);
    for (int i = 0; i < 3; i++) begin
      host_u.wr(NVM_IDLE_INTERVAL, ivs[i]);
      burst(va, gap, len);
      burst(va, g[i], len);
    end
    chk(16'(g[1] - g[0]), 16'd40);
    chk(16'(g[2] - g[0]), 16'd1320);
    host_u.wr(NVM_IDLE_INTERVAL, 8'h00);
    burst(va, gap, len);
    burst(va, gap, len);
    chk(16'(len), 16'd880);
    chk(16'(gap < 8), 16'h1);
    for (int i = 0; i < 6; i++) begin
      a = (i < 5) ? nv_tbl[i] : 7'(rnd());
      host_u.nvm_read(a, d, st);
      chk(16'(st[1:0]), 16'h3);
      chk(16'(d), 16'(nvm_byte(int'(a))));
    end
    host_u.rd(REG_NVM_ADDR, d);
    chk(16'(d), {9'h0, a});
    host_u.rd(8'h80, d);
    chk(16'(d), 16'h0);
    host_u.copy_set(7'h27);
    for (int k = 0; k < 6; k++) begin
      host_u.rd(8'(k < 3 ? 9 + k : 10 + k), d);
      chk(16'(d), 16'(nvm_byte(39 + k)));
    end
    host_u.wr(NVM_SWITCH_POLARITY_POINT, 8'ha5);
    host_u.wr(NVM_IDLE_INTERVAL, 8'h22);
    host_u.wr(REG_CTRL, 8'h03);
    wait_sig(1'b1, 1'b0, n);
    wait_sig(1'b1, 1'b1, n);
    chk(16'(n < 10), 16'h1);
    repeat (20) @(negedge ref_clk);
    host_u.rd(NVM_SWITCH_POLARITY_POINT, d);
    chk(16'(d), 16'h00a5);
    host_u.rd(NVM_IDLE_INTERVAL, d);
    chk(16'(d), 16'(nvm_byte(6)));
    host_u.wr(NVM_TAMPER_TIMER_FLAGS, 8'h02);
    host_u.wr(REG_CTRL, 8'h01);
    wait_sig(1'b1, 1'b0, n);
    n = 0;
    repeat (1000) begin
      @(negedge ref_clk);
      if (afe_power !== 1'b0) n++;
    end
    chk(16'(n), 16'h0);
    host_u.wr(REG_CTRL, 8'h00);
    wait_sig(1'b0, 1'b1, n);
    chk(16'(n < 100), 16'h1);
    host_u.rd(REG_CTRL, d);
    chk(16'(d), 16'h0080);
    stop_test();
  end
endmodule
`default_nettype wire

// file: bench/hif_host.sv
// Host model of the serial bus engine that drives the byte register port.
// Assumes the core takes strobes on the rising edge; this model moves on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module hif_host (
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  import hif_pkg::*;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h5a;
    reg_wdata = 8'ha5;
  end

  // Released lines show the inverse of the last value, so stale data cannot pass for fresh.
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = dv;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~dv;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dv);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    dv = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask

  task automatic nvm_read(input logic [6:0] a, output logic [7:0] dv, output logic [7:0] st);
    logic [7:0] s2;
    wr(REG_NVM_ADDR, {1'b0, a});
    wr(REG_NVM_CTRL, 8'h02);
    rd(REG_NVM_CTRL, st);
    for (int i = 0; i < 8; i++) begin
      rd(REG_NVM_CTRL, s2);
      if (s2[NVM_BUSY_BIT] === 1'b0) break;
    end
    rd(REG_NVM_DATA, dv);
  endtask

  // The device copies only the set at NVM_COEF_ZERO by itself, at each load; any other set the host has to.
  task automatic copy_set(input logic [6:0] base);
    logic [7:0] v;
    logic [7:0] st;
    for (int k = 0; k < 6; k++) begin
      nvm_read(base + 7'(k), v, st);
      wr(8'(k < 3 ? 9 + k : 10 + k), v);
    end
  endtask
endmodule
`default_nettype wire

// file: verilog/hif_core.sv
// Measurement scheduler, sample FIFO, FIR/IIR averaging filter and NVM read port.
// Assumes a byte register port driven by the two-wire bus engine and synchronous inputs.
`timescale 1ns/1ps
`default_nettype none

module hif_fifo #(
  parameter int W = 15,
  parameter int D = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hif_fifo_s;
  hif_fifo_s r;
  hif_fifo_s n;
  logic push;
  logic pop;
  assign in_ready = r.cnt != (AW+1)'(D);
  assign out_valid = r.cnt != '0;
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

module hif_core
#(
  parameter int WAKE_CYC = hif_pkg::WAKE_CYC_DEF,
  parameter logic [hif_pkg::NVM_DEPTH*8-1:0] NVM_IMAGE = '0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [hif_pkg::SAMPLE_W-1:0] afe_sample,
  output logic meas_active,
  output logic afe_power
);
  import hif_pkg::*;

  typedef struct packed {
    hif_state_e st;
    logic [CFG_NUM-1:0][7:0] cfg;
    logic sleep;
    logic usestore;
    logic waking;
    logic cont;
    logic [3:0] ld_idx;
    logic [CNT_W-1:0] cnt;
    logic [3:0] tick;
    logic [12:0] smp_cnt;
    logic push_v;
    logic [SAMPLE_W-1:0] push_d;
    logic [12:0] f_cnt;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] iacc;
    logic iinit;
    logic flt_pub;
    logic [SAMPLE_W-1:0] result;
    logic [7:0] res_lo;
    logic fresh;
    logic [7:0] nvm_addr;
    logic [7:0] nvm_data;
    logic nvm_busy;
    logic [2:0] nvm_cnt;
    logic [7:0] rdata;
    logic meas_o;
    logic pwr_o;
  } hif_core_s;

  hif_core_s r;
  hif_core_s n;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [SAMPLE_W-1:0] fifo_out_data;
  logic fifo_out_ready;

  // The memory image holds identity, serial, trim and six coefficient sets.
  function automatic logic [7:0] nvm_byte(input logic [7:0] a);
    return NVM_IMAGE[a[NVM_AW-1:0]*8 +: 8];
  endfunction

  // The filter stalls the FIFO while it publishes, so a slow drain backs up the sampler.
  assign fifo_out_ready = !r.flt_pub;

  hif_fifo #(.W(SAMPLE_W), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(r.push_v),
    .in_data(r.push_d),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  always_comb begin
    logic [3:0] bw;
    logic [2:0] bs;
    logic [12:0] nb;
    logic [7:0] ivl;
    logic fast;
    logic [5:0] mant;
    logic [3:0] ex;
    logic [CNT_W-1:0] ticks;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] inew;
    logic take;
    bw = r.cfg[IDX_FILTER][BW_LSB +: 4];
    bs = r.cfg[IDX_FILTER][BS_LSB +: 3];
    ivl = r.cfg[IDX_INTERVAL];
    fast = r.cfg[IDX_FLAGS][FLAG_FAST_BIT];
    sum = '0;
    inew = '0;
    take = fifo_out_valid && fifo_out_ready;
    n = r;
    if (bw > 4'(BW_MAX)) begin
      bw = 4'(BW_MAX);
    end
    // Burst length follows the bandwidth in FIR style, the burst size in IIR style.
    nb = r.cfg[IDX_FILTER][FILT_STYLE_BIT] ? (13'h1 << bs) : (13'h1 << bw);
    mant = 6'(IVL_BASE) + {1'b0, ivl[4:0]};
    ex = 4'(IVL_EXP_BASE) - (fast ? 4'(FAST_EXP_CUT) : 4'h0) + {1'b0, ivl[7:5]};
    ticks = CNT_W'(mant) << ex;
    n.push_v = 1'b0;
    n.flt_pub = 1'b0;

    if (r.nvm_busy) begin
      n.nvm_cnt = r.nvm_cnt - 3'h1;
      if (r.nvm_cnt == 3'h0) begin
        n.nvm_data = nvm_byte(r.nvm_addr);
        n.nvm_busy = 1'b0;
      end
    end

    n.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr >= NVM_CFG_FIRST && reg_addr <= REG_CFG_LAST) begin
        n.rdata = r.cfg[4'(reg_addr - NVM_CFG_FIRST)];
      end else begin
        unique case (reg_addr)
          REG_RES_HI: begin
            n.rdata = {r.fresh, r.result[14:8]};
            n.res_lo = r.result[7:0];
            n.fresh = 1'b0;
          end
          REG_RES_LO: n.rdata = r.res_lo;
          REG_CTRL: begin
            n.rdata[CTRL_SLEEP_BIT] = r.sleep;
            n.rdata[CTRL_USESTORE_BIT] = r.usestore;
            n.rdata[CTRL_MEAS_BIT] = r.meas_o;
          end
          REG_NVM_ADDR: n.rdata = r.nvm_addr;
          REG_NVM_DATA: n.rdata = r.nvm_data;
          REG_NVM_CTRL: begin
            n.rdata[NVM_BUSY_BIT] = r.nvm_busy;
            n.rdata[NVM_RDEN_BIT] = r.nvm_busy;
          end
          default: n.rdata = 8'h00;
        endcase
      end
    end

    if (reg_wr) begin
      if (reg_addr >= NVM_CFG_FIRST && reg_addr <= REG_CFG_LAST) begin
        n.cfg[4'(reg_addr - NVM_CFG_FIRST)] = reg_wdata;
      end else if (reg_addr == REG_CTRL) begin
        n.sleep = reg_wdata[CTRL_SLEEP_BIT];
        n.usestore = reg_wdata[CTRL_USESTORE_BIT];
      end else if (reg_addr == REG_NVM_ADDR) begin
        n.nvm_addr = reg_wdata;
      end else if (reg_addr == REG_NVM_CTRL && reg_wdata[NVM_RDEN_BIT] && !r.nvm_busy) begin
        n.nvm_busy = 1'b1;
        n.nvm_cnt = 3'(NVM_RD_CYC - 1);
      end
    end

    if (take) begin
      sum = r.acc + ACC_W'(fifo_out_data);
      n.acc = sum;
      n.f_cnt = r.f_cnt + 13'h1;
      // A bandwidth cut in mid burst must still end the burst, so compare with at least.
      if (r.f_cnt + 13'h1 >= nb) begin
        n.acc = '0;
        n.f_cnt = '0;
        n.flt_pub = 1'b1;
        n.fresh = 1'b1;
        if (!r.cfg[IDX_FILTER][FILT_STYLE_BIT]) begin
          n.result = SAMPLE_W'(sum >> bw);
        end else begin
          sum = sum >> bs;
          // The IIR state keeps the output scaled by 2^bw so no fraction bits are lost.
          inew = r.iinit ? (sum << bw) : r.iacc - (r.iacc >> bw) + sum;
          n.iacc = inew;
          n.iinit = 1'b0;
          n.result = SAMPLE_W'(inew >> bw);
        end
      end
    end

    unique case (r.st)
      ST_LOAD: begin
        if (!(r.waking && r.usestore && r.ld_idx < 4'(STORE_KEEP_NUM))) begin
          n.cfg[r.ld_idx] = nvm_byte(NVM_CFG_FIRST + 8'(r.ld_idx));
        end
        n.ld_idx = r.ld_idx + 4'h1;
        if (r.ld_idx == 4'(CFG_NUM - 1)) begin
          n.ld_idx = 4'h0;
          n.waking = 1'b0;
          n.st = ST_MEAS;
          n.cont = 1'b0;
          n.cnt = CNT_W'(FIRST_CYC);
          n.smp_cnt = '0;
        end
      end
      ST_MEAS: begin
        if (r.cnt != CNT_W'(1)) begin
          n.cnt = r.cnt - CNT_W'(1);
        end else if (fifo_in_ready) begin
          n.push_v = 1'b1;
          n.push_d = afe_sample;
          n.cnt = CNT_W'(NEXT_CYC);
          n.smp_cnt = r.smp_cnt + 13'h1;
          if (r.smp_cnt + 13'h1 >= nb) begin
            n.st = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (r.flt_pub) begin
          if (r.sleep) begin
            n.st = ST_SLEEP;
            n.cnt = fast ? CNT_W'(WAKE_CYC >> FAST_EXP_CUT) : CNT_W'(WAKE_CYC);
          end else if (fast && ivl == 8'h00) begin
            n.st = ST_MEAS;
            n.cont = 1'b1;
            n.cnt = CNT_W'(NEXT_CYC);
            n.smp_cnt = '0;
          end else begin
            n.st = ST_IDLE;
            n.cnt = ticks;
            n.tick = 4'h0;
          end
        end
      end
      ST_IDLE: begin
        n.tick = (r.tick == 4'(TICK_CYC - 1)) ? 4'h0 : r.tick + 4'h1;
        if (r.tick == 4'(TICK_CYC - 1)) begin
          n.cnt = r.cnt - CNT_W'(1);
        end
        if (r.cnt == '0 || (r.cnt == CNT_W'(1) && r.tick == 4'(TICK_CYC - 1))) begin
          n.st = ST_MEAS;
          n.cont = 1'b0;
          n.cnt = CNT_W'(FIRST_CYC);
          n.smp_cnt = '0;
        end
      end
      ST_SLEEP: begin
        if (r.cfg[IDX_FLAGS][FLAG_TIMER_BIT] && r.cnt != '0) begin
          n.cnt = r.cnt - CNT_W'(1);
        end
        // Timer off holds here until the sleep bit is cleared.
        if (!r.sleep || (r.cfg[IDX_FLAGS][FLAG_TIMER_BIT] && r.cnt == CNT_W'(1))) begin
          n.st = ST_LOAD;
          n.waking = 1'b1;
          n.ld_idx = 4'h0;
        end
      end
    endcase
    n.meas_o = n.st == ST_MEAS;
    n.pwr_o = n.st != ST_SLEEP;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r <= '0;
      r.iinit <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign meas_active = r.meas_o;
  assign afe_power = r.pwr_o;

  sequence seq_nvm_req;
    reg_wr && reg_addr == REG_NVM_CTRL && reg_wdata[NVM_RDEN_BIT] && !r.nvm_busy;
  endsequence
  sequence seq_nvm_done;
    r.nvm_busy [*4] ##1 !r.nvm_busy;
  endsequence
  sequence seq_load_start;
    r.st == ST_LOAD && $past(r.st) != ST_LOAD;
  endsequence

  AST_NVM_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    seq_nvm_req |=> seq_nvm_done) else $error("NVM read busy length wrong");
  AST_NVM_DATA: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(r.nvm_busy) |-> r.nvm_data == nvm_byte(r.nvm_addr))
    else $error("NVM data not from address");
  AST_LOAD_LEN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    seq_load_start |-> (r.st == ST_LOAD) [*8] ##1 (r.st == ST_LOAD) [*4] ##1 r.st == ST_MEAS)
    else $error("Load did not copy twelve bytes");
  AST_FIRST_MEAS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (r.st == ST_MEAS && $past(r.st) != ST_MEAS && !r.cont) |-> r.cnt == CNT_W'(FIRST_CYC))
    else $error("First measurement time wrong");
  AST_NEXT_MEAS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.push_v && r.st == ST_MEAS |-> r.cnt == CNT_W'(NEXT_CYC))
    else $error("Next measurement time wrong");
  AST_ZERO_IDLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.st == ST_DRAIN && r.flt_pub && !r.sleep && r.cfg[IDX_FLAGS][FLAG_FAST_BIT]
    && r.cfg[IDX_INTERVAL] == 8'h00 |=> r.st == ST_MEAS && r.cont)
    else $error("Zero idle not applied");
  AST_IDLE_LEN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.st == ST_IDLE && $past(r.st) == ST_DRAIN |-> r.cnt ==
    (CNT_W'(6'(IVL_BASE) + {1'b0, r.cfg[IDX_INTERVAL][4:0]}) << (4'(IVL_EXP_BASE)
    - (r.cfg[IDX_FLAGS][FLAG_FAST_BIT] ? 4'(FAST_EXP_CUT) : 4'h0)
    + {1'b0, r.cfg[IDX_INTERVAL][7:5]})))
    else $error("Idle count wrong");
  AST_RESULT_BURST: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !$stable(r.result) |-> r.flt_pub) else $error("Result changed mid burst");
  AST_DEEP_SLEEP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.st == ST_SLEEP && r.sleep && !r.cfg[IDX_FLAGS][FLAG_TIMER_BIT] && !reg_wr
    |=> r.st == ST_SLEEP) else $error("Left sleep without timer");
  AST_BW_CAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    r.f_cnt <= 13'h1000) else $error("Burst longer than 4096");
endmodule

`default_nettype wire

// file: verilog/hif_pkg.sv
// Constants, field layout and state codes of the hall sensor idle timer, filter and NVM reader.
// Assumes a single 100 MHz clock; all other files import this package.
package hif_pkg;
  localparam int CLK_MHZ = 100;
  localparam int OSC_MHZ = 10;
  localparam int TICK_CYC = CLK_MHZ / OSC_MHZ;
  localparam real T_FIRST_US = 11.0;
  localparam real T_NEXT_US = 8.8;
  localparam int FIRST_CYC = int'(T_FIRST_US * CLK_MHZ);
  localparam int NEXT_CYC = int'(T_NEXT_US * CLK_MHZ);
  localparam int T_WAKE_MS = 10;
  localparam int WAKE_CYC_DEF = T_WAKE_MS * CLK_MHZ * 1000;
  localparam int NVM_RD_CYC = 4;
  localparam int SAMPLE_W = 15;
  localparam int ACC_W = 27;
  localparam int CNT_W = 25;
  localparam int NVM_AW = 7;
  localparam int NVM_DEPTH = 128;
  localparam int CFG_NUM = 12;
  localparam int BW_MAX = 12;
  localparam int IVL_BASE = 32;
  localparam int IVL_EXP_BASE = 8;
  localparam int FAST_EXP_CUT = 6;
  localparam int FIFO_DEPTH = 4;
  // Byte addresses inside the nonvolatile memory.
  localparam logic [7:0] NVM_SWITCH_POLARITY_POINT = 8'h04, NVM_SWITCH_SIGN_HYSTERESIS = 8'h05,
    NVM_IDLE_INTERVAL = 8'h06, NVM_TAMPER_TIMER_FLAGS = 8'h08, NVM_COEF_ZERO = 8'h09,
    NVM_COEF_ONE = 8'h0a, NVM_COEF_TWO = 8'h0b, NVM_FILTER_CONFIG = 8'h0c,
    NVM_COEF_THREE = 8'h0d, NVM_COEF_FOUR = 8'h0e, NVM_COEF_FIVE = 8'h0f,
    NVM_BASE_PART_NUMBER = 8'h14, NVM_VARIANT = 8'h15, NVM_TEMP_OFFSET_TRIM = 8'h1d,
    NVM_TEMP_GAIN_TRIM = 8'h1e;
  localparam logic [7:0] NVM_CFG_FIRST = NVM_SWITCH_POLARITY_POINT;
  // Register port addresses; configuration copies sit at their memory byte address.
  localparam logic [7:0] REG_CFG_LAST = NVM_COEF_FIVE;
  localparam logic [7:0] REG_RES_HI = 8'hc1;
  localparam logic [7:0] REG_RES_LO = 8'hc2;
  localparam logic [7:0] REG_CTRL = 8'hc4;
  localparam logic [7:0] REG_NVM_ADDR = 8'he1;
  localparam logic [7:0] REG_NVM_DATA = 8'he2;
  localparam logic [7:0] REG_NVM_CTRL = 8'he3;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_USESTORE_BIT = 1;
  localparam int CTRL_MEAS_BIT = 7;
  localparam int NVM_BUSY_BIT = 0;
  localparam int NVM_RDEN_BIT = 1;
  localparam int IDX_INTERVAL = int'(NVM_IDLE_INTERVAL - NVM_CFG_FIRST);
  localparam int IDX_FLAGS = int'(NVM_TAMPER_TIMER_FLAGS - NVM_CFG_FIRST);
  localparam int IDX_FILTER = int'(NVM_FILTER_CONFIG - NVM_CFG_FIRST);
  localparam int FLAG_TIMER_BIT = 0;
  localparam int FLAG_FAST_BIT = 1;
  localparam int FILT_STYLE_BIT = 0;
  localparam int BW_LSB = 1;
  localparam int BS_LSB = 5;
  localparam int STORE_KEEP_NUM = 2;
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000, ST_MEAS = 3'b001, ST_DRAIN = 3'b011, ST_IDLE = 3'b010, ST_SLEEP = 3'b110
  } hif_state_e;
endpackage
